// ### daaf_core.v
/*
 * condition flags and data address generation for one core slice.
 * assumes a decoder presenting one operation at a time while o_busy is low, and a
 * data memory that returns read data one cycle after o_mem_rd is sampled.
 */
// Behaviour
// - flag-altering op aimed at the flag register updates flags only, result dropped.
// - clearing the flag register sets zero, keeps other flags.
// - bit clear/set, swap, full move, accumulator store alter flags only when written to the flag register.
// - upper three flag bits read zero.
// - negative flag follows result bit 7.
// - overflow flag set when signed result flips sign bit wrongly.
// - zero flag set when result equals zero.
// - add/subtract ops capture carry out of bit 3 as digit carry.
// - add/subtract ops capture carry out of bit 7 as carry.
// - subtract adds two's complement, carries act as inverted borrows.
// - rotates load digit carry from bit 4 or 3, carry from end bit.
// - file address joins bank value when access bit set, else access bank.
// - full-address moves ignore the bank value.
// - destination bit one writes file, zero writes accumulator.
// - jump carries a 20-bit program address.
// - three pointer pairs, each a 12-bit linear address.
// - indirect operands have no storage; they access memory at their pointer.
// - indirect access uses full pointer, ignoring bank value and access bit.
// - pointer bytes are readable and writable by direct access.
// - each pair offers incrementing, decrementing and offset operands.
// - indexed literal offset works only with extended set enabled.
// - post ops access then step, pre-increment steps first, indexed adds accumulator.
// - pointer steps carry across the whole pair and alter no flag.
// - pointer aimed at an indirect operand reads zero, writes nothing.
// - write through a pair's own operand stores value without stepping.
`include "daaf_defines.vh"

module daaf_core #(
	parameter PROG_W = 20
) (
	input  wire              i_clk,
	input  wire              i_reset,
	input  wire              i_instr_valid,
	input  wire [4:0]        i_op,
	input  wire [7:0]        i_file,
	input  wire              i_access,
	input  wire              i_dest,
	input  wire [2:0]        i_bit_sel,
	input  wire [7:0]        i_literal,
	input  wire              i_full_en,
	input  wire [11:0]       i_full_src,
	input  wire [11:0]       i_full_dst,
	input  wire [1:0]        i_ptr_sel,
	input  wire [PROG_W-1:0] i_prog_literal,
	input  wire [3:0]        i_bank_select_value,
	input  wire              i_extended_set_enable,
	input  wire [7:0]        i_accum,
	input  wire [7:0]        i_mem_rdata,
	output reg               o_busy,
	output reg               o_done,
	output reg  [11:0]       o_mem_addr,
	output reg               o_mem_rd,
	output reg               o_mem_wr,
	output reg  [7:0]        o_mem_wdata,
	output reg               o_accum_wr,
	output reg  [7:0]        o_accum_data,
	output wire [7:0]        o_flags,
	output reg               o_prog_load,
	output reg  [PROG_W-1:0] o_prog_target
);

	localparam S_IDLE = 3'b001;
	localparam S_WAIT = 3'b010;
	localparam S_EXEC = 3'b100;

	// ********************************
	// decoding helpers
	// ********************************
	function [1:0] pair_of;
		input [11:0] addr;
		begin
			case (addr[11:3])
				`DAAF_PAIR0_BLOCK: pair_of = 2'h0;
				`DAAF_PAIR1_BLOCK: pair_of = 2'h1;
				`DAAF_PAIR2_BLOCK: pair_of = 2'h2;
				default: pair_of = `DAAF_NO_PAIR;
			endcase
		end
	endfunction

	function [4:0] flag_mask;
		input [4:0] op;
		begin
			case (op)
				`DAAF_OP_ADD_REG, `DAAF_OP_ADD_IMM, `DAAF_OP_SUB_IMM, `DAAF_OP_SUB_REG:
					flag_mask = 5'h1f;
				`DAAF_OP_AND_REG, `DAAF_OP_IOR_REG, `DAAF_OP_XOR_REG, `DAAF_OP_MOVE_REG:
					flag_mask = 5'h14;
				`DAAF_OP_ROT_R, `DAAF_OP_ROT_L: flag_mask = 5'h17;
				`DAAF_OP_CLEAR: flag_mask = 5'h04;
				default: flag_mask = 5'h00;
			endcase
		end
	endfunction

	function needs_read;
		input [4:0] op;
		begin
			case (op)
				`DAAF_OP_ADD_IMM, `DAAF_OP_SUB_IMM, `DAAF_OP_CLEAR, `DAAF_OP_STORE_ACC,
				`DAAF_OP_LOAD_PTR, `DAAF_OP_PROG_JUMP: needs_read = 1'b0;
				default: needs_read = 1'b1;
			endcase
		end
	endfunction

	// ********************************
	// state
	// ********************************
	reg  [2:0]        state;
	reg  [4:0]        flags;
	reg  [4:0]        op_q;
	reg               dest_q;
	reg  [2:0]        bit_q;
	reg  [7:0]        lit_q;
	reg  [7:0]        accum_q;
	reg  [11:0]       eff_q;
	reg  [11:0]       dst_q;
	reg  [1:0]        upd_pair_q;
	reg  [2:0]        upd_mode_q;
	reg  [1:0]        ptr_sel_q;
	reg  [PROG_W-1:0] prog_q;
	wire [11:0]       ptr_val [0:2];

	assign o_flags = {3'h0, flags};

	// ********************************
	// address resolution at accept
	// ********************************
	reg  [11:0] base;
	reg  [1:0]  base_pair;
	reg  [11:0] eff;
	reg  [1:0]  upd_pair;
	reg  [1:0]  eff_pair;

	always @* begin
		if (i_full_en) begin
			base = i_full_src;
		end else if (i_access) begin
			base = {i_bank_select_value, i_file};
		end else if (i_extended_set_enable && i_file <= `DAAF_INDEX_LIMIT) begin
			base = ptr_val[2] + {4'h0, i_file};
		end else if (i_file[7]) begin
			base = {`DAAF_ACCESS_HIGH_BANK, i_file};
		end else begin
			base = {`DAAF_ACCESS_LOW_BANK, i_file};
		end
		base_pair = pair_of(base);
		eff = base;
		upd_pair = `DAAF_NO_PAIR;
		// the operand itself has no storage; the pointer stands in for it
		if (base_pair != `DAAF_NO_PAIR && base[2:0] >= `DAAF_OFS_INDEX) begin
			upd_pair = base_pair;
			case (base[2:0])
				`DAAF_OFS_INDEX: eff = ptr_val[base_pair] + {{4{i_accum[7]}}, i_accum};
				`DAAF_OFS_PRE_INCREMENT_OPERAND: eff = ptr_val[base_pair] + 12'h001;
				default: eff = ptr_val[base_pair];
			endcase
		end
		eff_pair = pair_of(eff);
	end

	// ********************************
	// execution datapath
	// ********************************
	reg  [7:0]  src;
	reg  [7:0]  opa;
	reg  [7:0]  addend;
	reg         cin;
	reg  [8:0]  sum9;
	reg  [4:0]  sum5;
	reg  [7:0]  res;
	reg  [4:0]  cand;
	reg  [4:0]  mask;
	reg  [4:0]  next_flags;
	reg         to_file;
	reg  [11:0] wa;
	reg  [1:0]  wa_pair;
	reg  [1:0]  rd_pair;

	always @* begin
		rd_pair = pair_of(eff_q);
		// pointer bytes and flags are read here; operand or gap addresses give zero
		if (eff_q == `DAAF_FLAGS_ADDR) begin
			src = {3'h0, flags};
		end else if (rd_pair != `DAAF_NO_PAIR) begin
			if (eff_q[2:0] == `DAAF_OFS_LOW) begin
				src = ptr_val[rd_pair][7:0];
			end else if (eff_q[2:0] == `DAAF_OFS_HIGH) begin
				src = {4'h0, ptr_val[rd_pair][11:8]};
			end else begin
				src = 8'h00;
			end
		end else begin
			src = i_mem_rdata;
		end
		opa = (op_q == `DAAF_OP_ADD_IMM || op_q == `DAAF_OP_SUB_IMM) ? lit_q : src;
		cin = (op_q == `DAAF_OP_SUB_IMM || op_q == `DAAF_OP_SUB_REG);
		addend = cin ? ~accum_q : accum_q;
		sum9 = {1'b0, opa} + {1'b0, addend} + {8'h00, cin};
		sum5 = {1'b0, opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
		cand = 5'h00;
		cand[`DAAF_BIT_DIGIT] = sum5[4];
		cand[`DAAF_BIT_CARRY] = sum9[8];
		cand[`DAAF_BIT_OVF] = (opa[7] == addend[7]) && (sum9[7] != opa[7]);
		case (op_q)
			`DAAF_OP_AND_REG: res = src & accum_q;
			`DAAF_OP_IOR_REG: res = src | accum_q;
			`DAAF_OP_XOR_REG: res = src ^ accum_q;
			`DAAF_OP_MOVE_REG, `DAAF_OP_MOVE_FULL: res = src;
			`DAAF_OP_CLEAR: res = 8'h00;
			`DAAF_OP_ROT_R: begin
				res = {flags[`DAAF_BIT_CARRY], src[7:1]};
				cand[`DAAF_BIT_CARRY] = src[0];
				cand[`DAAF_BIT_DIGIT] = src[4];
			end
			`DAAF_OP_ROT_L: begin
				res = {src[6:0], flags[`DAAF_BIT_CARRY]};
				cand[`DAAF_BIT_CARRY] = src[7];
				cand[`DAAF_BIT_DIGIT] = src[3];
			end
			`DAAF_OP_BIT_CLR: res = src & ~(8'h01 << bit_q);
			`DAAF_OP_BIT_SET: res = src | (8'h01 << bit_q);
			`DAAF_OP_SWAP: res = {src[3:0], src[7:4]};
			`DAAF_OP_STORE_ACC: res = accum_q;
			default: res = sum9[7:0];
		endcase
		cand[`DAAF_BIT_NEG] = res[7];
		cand[`DAAF_BIT_ZERO] = (res == 8'h00);
		mask = flag_mask(op_q);
		next_flags = (flags & ~mask) | (cand & mask);
		case (op_q)
			`DAAF_OP_CLEAR, `DAAF_OP_BIT_CLR, `DAAF_OP_BIT_SET, `DAAF_OP_STORE_ACC,
			`DAAF_OP_MOVE_FULL: to_file = 1'b1;
			`DAAF_OP_ADD_IMM, `DAAF_OP_SUB_IMM, `DAAF_OP_LOAD_PTR,
			`DAAF_OP_PROG_JUMP: to_file = 1'b0;
			default: to_file = dest_q;
		endcase
		wa = (op_q == `DAAF_OP_MOVE_FULL) ? dst_q : eff_q;
		wa_pair = pair_of(wa);
	end

	// ********************************
	// pointer pairs
	// ********************************
	genvar n;
	generate
		for (n = 0; n < 3; n = n + 1) begin : g_pair
			reg [11:0] pval;
			assign ptr_val[n] = pval;
			always @(posedge i_clk) begin
				if (i_reset) begin
					pval <= `DAAF_PTR_RESET;
				end else if (state == S_EXEC) begin
					// a write landing on the pair beats its own step
					if (to_file && wa_pair == n && wa[2:0] == `DAAF_OFS_LOW) begin
						pval[7:0] <= res;
					end else if (to_file && wa_pair == n && wa[2:0] == `DAAF_OFS_HIGH) begin
						pval[11:8] <= res[3:0];
					end else if (op_q == `DAAF_OP_LOAD_PTR && ptr_sel_q == n) begin
						pval <= eff_q;
					end else if (upd_pair_q == n) begin
						case (upd_mode_q)
							`DAAF_OFS_POST_INCREMENT_OPERAND, `DAAF_OFS_PRE_INCREMENT_OPERAND: pval <= pval + 12'h001;
							`DAAF_OFS_POST_DECREMENT_OPERAND: pval <= pval - 12'h001;
							default: pval <= pval;
						endcase
					end
				end
			end
		end
	endgenerate

	// ********************************
	// sequencer, flags and outputs
	// ********************************
	always @(posedge i_clk) begin
		if (i_reset) begin
			state <= S_IDLE;
			flags <= `DAAF_FLAGS_RESET;
			op_q <= 5'h00;
			dest_q <= 1'b0;
			bit_q <= 3'h0;
			lit_q <= 8'h00;
			accum_q <= 8'h00;
			eff_q <= 12'h000;
			dst_q <= 12'h000;
			upd_pair_q <= `DAAF_NO_PAIR;
			upd_mode_q <= 3'h0;
			ptr_sel_q <= 2'h0;
			prog_q <= {PROG_W{1'b0}};
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_mem_addr <= 12'h000;
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			o_mem_wdata <= 8'h00;
			o_accum_wr <= 1'b0;
			o_accum_data <= 8'h00;
			o_prog_load <= 1'b0;
			o_prog_target <= {PROG_W{1'b0}};
		end else begin
			o_done <= 1'b0;
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			o_accum_wr <= 1'b0;
			o_prog_load <= 1'b0;
			case (state)
				S_IDLE: begin
					if (i_instr_valid) begin
						state <= S_WAIT;
						o_busy <= 1'b1;
						op_q <= i_op;
						dest_q <= i_dest;
						bit_q <= i_bit_sel;
						lit_q <= i_literal;
						accum_q <= i_accum;
						dst_q <= i_full_dst;
						ptr_sel_q <= i_ptr_sel;
						prog_q <= i_prog_literal;
						eff_q <= (i_op == `DAAF_OP_LOAD_PTR) ? i_full_src : eff;
						upd_pair_q <= (i_op == `DAAF_OP_LOAD_PTR) ? `DAAF_NO_PAIR : upd_pair;
						upd_mode_q <= base[2:0];
						o_mem_addr <= eff;
						// internal registers and indirect operands never reach memory
						o_mem_rd <= needs_read(i_op) && eff != `DAAF_FLAGS_ADDR &&
							eff_pair == `DAAF_NO_PAIR && i_op != `DAAF_OP_LOAD_PTR;
					end
				end
				S_WAIT: begin
					state <= S_EXEC;
				end
				S_EXEC: begin
					state <= S_IDLE;
					o_busy <= 1'b0;
					o_done <= 1'b1;
					if (mask != 5'h00) begin
						flags <= next_flags;
					end else if (to_file && wa == `DAAF_FLAGS_ADDR) begin
						flags <= res[4:0];
					end
					if (to_file && wa != `DAAF_FLAGS_ADDR && wa_pair == `DAAF_NO_PAIR) begin
						o_mem_wr <= 1'b1;
						o_mem_addr <= wa;
						o_mem_wdata <= res;
					end
					if (!to_file && op_q != `DAAF_OP_LOAD_PTR && op_q != `DAAF_OP_PROG_JUMP) begin
						o_accum_wr <= 1'b1;
						o_accum_data <= res;
					end
					if (op_q == `DAAF_OP_PROG_JUMP) begin
						o_prog_load <= 1'b1;
						o_prog_target <= prog_q;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

endmodule

// ### daaf_core_properties.sv
/* assertions on the top ports of the flag and address slice.
   assumes the fixed three-edge latency and a bind from the bench top. */
`include "daaf_defines.vh"
module daaf_core_properties #(
	parameter PROG_W = 20
) (
	input logic              i_clk,
	input logic              i_reset,
	input logic              i_instr_valid,
	input logic [4:0]        i_op,
	input logic [7:0]        i_file,
	input logic              i_access,
	input logic              i_dest,
	input logic [7:0]        i_literal,
	input logic [PROG_W-1:0] i_prog_literal,
	input logic [3:0]        i_bank_select_value,
	input logic              i_extended_set_enable,
	input logic [7:0]        i_accum,
	input logic              o_busy,
	input logic              o_done,
	input logic [11:0]       o_mem_addr,
	input logic              o_mem_rd,
	input logic              o_mem_wr,
	input logic              o_accum_wr,
	input logic [7:0]        o_flags,
	input logic              o_prog_load,
	input logic [PROG_W-1:0] o_prog_target
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acc;
	logic bank;
	assign acc = i_instr_valid && !o_busy;
	assign bank = i_access && (i_bank_select_value != 4'hf);
	function automatic logic [4:0] fl(input logic [7:0] a, b, input logic c);
		logic [8:0] s;
		logic [4:0] h;
		s = a + b + c;
		h = a[3:0] + b[3:0] + c;
		fl = {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
	endfunction
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// ****************************
	// flags
	// ****************************
	flags_top_zero_a: assert property (o_flags[7:5] == 3'h0)
		else $error("flag upper bits not zero");
	add_imm_flags_a: assert property (acc && i_op == `DAAF_OP_ADD_IMM |-> ##3 o_accum_wr &&
		o_flags[4:0] == fl($past(i_literal, 3), $past(i_accum, 3), 1'h0))
		else $error("add immediate flags wrong");
	sub_imm_flags_a: assert property (acc && i_op == `DAAF_OP_SUB_IMM |-> ##3
		o_flags[4:0] == fl($past(i_literal, 3), ~$past(i_accum, 3), 1'h1))
		else $error("subtract immediate flags wrong");
	neutral_ops_a: assert property (acc && bank && (i_op == `DAAF_OP_SWAP ||
		i_op == `DAAF_OP_STORE_ACC || i_op == `DAAF_OP_BIT_CLR || i_op == `DAAF_OP_BIT_SET)
		|=> $stable(o_flags) [*3])
		else $error("flag-neutral op changed flags");
	clear_flags_a: assert property (acc && i_op == `DAAF_OP_CLEAR && !i_access &&
		i_file == 8'hd0 && !i_extended_set_enable |-> ##3 !o_mem_wr &&
		o_flags == {3'h0, $past(o_flags[4:3], 3), 1'h1, $past(o_flags[1:0], 3)})
		else $error("clear of flag register wrong");
	flag_dest_a: assert property (acc && i_op == `DAAF_OP_ADD_REG && !i_access &&
		i_file == 8'hd0 && !i_extended_set_enable |-> ##3 o_done && !o_mem_wr)
		else $error("result written to flag register");
	// ****************************
	// addressing
	// ****************************
	bank_addr_a: assert property (acc && i_op == `DAAF_OP_ADD_REG && bank |=>
		o_mem_rd && o_mem_addr == {$past(i_bank_select_value), $past(i_file)})
		else $error("banked address wrong");
	access_low_a: assert property (acc && i_op == `DAAF_OP_ADD_REG && !i_access &&
		!i_extended_set_enable && !i_file[7] |=> o_mem_rd && o_mem_addr == {4'h0, $past(i_file)})
		else $error("access bank address wrong");
	dest_file_a: assert property (acc && i_op == `DAAF_OP_ADD_REG && bank && i_dest
		|-> ##3 o_mem_wr && !o_accum_wr)
		else $error("file destination not written");
	dest_acc_a: assert property (acc && i_op == `DAAF_OP_ADD_REG && bank && !i_dest
		|-> ##3 o_accum_wr && !o_mem_wr)
		else $error("accumulator destination not written");
	prog_jump_a: assert property (acc && i_op == `DAAF_OP_PROG_JUMP |-> ##3 o_prog_load &&
		o_prog_target == $past(i_prog_literal, 3))
		else $error("program target wrong");
	cover property (acc && i_op == `DAAF_OP_SUB_IMM);
	cover property (acc && i_op == `DAAF_OP_CLEAR && i_file == 8'hd0);
	cover property (o_prog_load);
endmodule

// ### daaf_defines.vh
/*
 * constants for the condition-flag and data-address slice: special register map,
 * operand offsets inside a pointer block, flag positions, reset values, operation codes.
 * assumes it is included by bare name from the slice's design file.
 */
`ifndef DAAF_DEFINES_VH
`define DAAF_DEFINES_VH

// ********************************
// special register map
// ********************************
`define DAAF_FLAGS_ADDR      12'hfd0
`define DAAF_PAIR0_BLOCK     9'h1fd
`define DAAF_PAIR1_BLOCK     9'h1fc
`define DAAF_PAIR2_BLOCK     9'h1fb
`define DAAF_NO_PAIR         2'h3

// ********************************
// offsets inside one pointer block
// ********************************
`define DAAF_OFS_LOW         3'h0
`define DAAF_OFS_HIGH        3'h1
`define DAAF_OFS_INDEX       3'h3
`define DAAF_OFS_PRE_INCREMENT_OPERAND      3'h4
`define DAAF_OFS_POST_DECREMENT_OPERAND     3'h5
`define DAAF_OFS_POST_INCREMENT_OPERAND     3'h6
`define DAAF_OFS_PLAIN       3'h7

// ********************************
// flag bit positions and resets
// ********************************
`define DAAF_BIT_NEG         4
`define DAAF_BIT_OVF         3
`define DAAF_BIT_ZERO        2
`define DAAF_BIT_DIGIT       1
`define DAAF_BIT_CARRY       0
`define DAAF_FLAGS_RESET     5'h00
`define DAAF_PTR_RESET       12'h000

// ********************************
// access bank and indexed literal window
// ********************************
`define DAAF_ACCESS_LOW_BANK  4'h0
`define DAAF_ACCESS_HIGH_BANK 4'hf
`define DAAF_INDEX_LIMIT      8'h5f

// ********************************
// operation codes from the decoder
// ********************************
`define DAAF_OP_ADD_REG      5'h00
`define DAAF_OP_ADD_IMM      5'h01
`define DAAF_OP_SUB_IMM      5'h02
`define DAAF_OP_SUB_REG      5'h03
`define DAAF_OP_AND_REG      5'h04
`define DAAF_OP_IOR_REG      5'h05
`define DAAF_OP_XOR_REG      5'h06
`define DAAF_OP_MOVE_REG     5'h07
`define DAAF_OP_CLEAR        5'h08
`define DAAF_OP_ROT_R        5'h09
`define DAAF_OP_ROT_L        5'h0a
`define DAAF_OP_BIT_CLR      5'h0b
`define DAAF_OP_BIT_SET      5'h0c
`define DAAF_OP_SWAP         5'h0d
`define DAAF_OP_STORE_ACC    5'h0e
`define DAAF_OP_MOVE_FULL    5'h0f
`define DAAF_OP_LOAD_PTR     5'h10
`define DAAF_OP_PROG_JUMP    5'h11

`endif

// ### daaf_mem_model.sv
/* data memory model for the slice bench: one-cycle read latency, byte writes.
   assumes single-cycle read and write strobes from the slice. */
module daaf_mem_model (
	input  logic        i_clk,
	input  logic        i_mem_rd,
	input  logic        i_mem_wr,
	input  logic [11:0] i_mem_addr,
	input  logic [7:0]  i_mem_wdata,
	output logic [7:0]  o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [4096];
	initial begin
		for (int a = 0; a < 4096; a++)
			mem[a] = a[7:0] ^ 8'h3c;
		o_rdata = 8'h00;
	end
	// data toggles outside the read cycle so a late sample cannot pass by luck
	always @(posedge i_clk) begin
		if (i_mem_wr)
			mem[i_mem_addr] <= i_mem_wdata;
		if (i_mem_rd)
			o_rdata <= mem[i_mem_addr];
		else
			o_rdata <= ~o_rdata;
	end
endmodule

// ### tb_top.sv
/* directed bench for the flag and address slice: the bench plays the decoder.
   assumes the memory model and the checker file compiled before it. */
`include "daaf_defines.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk, i_reset, i_instr_valid, i_access, i_dest, i_full_en;
	logic        i_extended_set_enable;
	logic [4:0]  i_op;
	logic [7:0]  i_file, i_literal, i_accum;
	logic [2:0]  i_bit_sel;
	logic [11:0] i_full_src, i_full_dst;
	logic [1:0]  i_ptr_sel;
	logic [19:0] i_prog_literal;
	logic [3:0]  i_bank_select_value;
	wire         o_busy, o_done, o_mem_rd, o_mem_wr, o_accum_wr, o_prog_load;
	wire  [11:0] o_mem_addr;
	wire  [7:0]  i_mem_rdata, o_mem_wdata, o_accum_data, o_flags;
	wire  [19:0] o_prog_target;
	int          mismatches, n_compared, cyc;
	logic        rd, wr, aw, pl;
	logic [11:0] ra, wa;
	logic [7:0]  wd, ad, fs;
	logic [7:0]  ka [4] = '{8'h7f, 8'hff, 8'h0f, 8'h80};
	logic [7:0]  kw [4] = '{8'h01, 8'h01, 8'h01, 8'h80};
	logic [4:0]  nop [4] = '{`DAAF_OP_SWAP, `DAAF_OP_STORE_ACC, `DAAF_OP_BIT_CLR, `DAAF_OP_BIT_SET};
	logic [7:0]  kd [4] = '{8'hc2, 8'h01, 8'h01, 8'h21};
	logic [7:0]  pf [5] = '{8'hee, 8'hed, 8'hec, 8'hef, 8'heb};
	logic [11:0] pa [5] = '{12'h0ff, 12'h100, 12'h100, 12'h100, 12'h0fe};
	daaf_core DUT (.i_clk, .i_reset, .i_instr_valid, .i_op, .i_file, .i_access, .i_dest,
		.i_bit_sel, .i_literal, .i_full_en, .i_full_src, .i_full_dst, .i_ptr_sel,
		.i_prog_literal, .i_bank_select_value, .i_extended_set_enable, .i_accum,
		.i_mem_rdata, .o_busy, .o_done, .o_mem_addr, .o_mem_rd, .o_mem_wr, .o_mem_wdata,
		.o_accum_wr, .o_accum_data, .o_flags, .o_prog_load, .o_prog_target);
	daaf_mem_model u_mem (.i_clk, .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr),
		.i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
	function automatic logic [12:0] fl(input logic [7:0] a, b, input logic c);
		logic [8:0] s;
		logic [4:0] h;
		s = a + b + c;
		h = a[3:0] + b[3:0] + c;
		fl = {s[7:0], s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
	endfunction
	// ****************************
	// access tasks
	// ****************************
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// called at a falling edge; returns at the falling edge of the done cycle
	task automatic ex(input logic [4:0] op, input logic [7:0] f, input logic a, d);
		int n;
		n = 0;
		i_op = op;
		i_file = f;
		i_access = a;
		i_dest = d;
		i_instr_valid = 1'h1;
		@(negedge i_clk);
		i_instr_valid = 1'h0;
		rd = o_mem_rd;
		ra = o_mem_addr;
		while (o_done !== 1'h1 && n < 8) begin
			@(negedge i_clk);
			n++;
		end
		if (n == 8)
			chk("done", 32'h0, 32'h1);
		{wr, wa, wd, aw, ad, pl} = {o_mem_wr, o_mem_addr, o_mem_wdata, o_accum_wr, o_accum_data, o_prog_load};
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		i_clk = 1'h0;
		forever #4 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			results;
		end
	end
	// ****************************
	// scenarios
	// ****************************
	initial begin
		{i_reset, i_instr_valid, i_op, i_file, i_access, i_dest, i_bit_sel, i_literal} = 28'h8000000;
		{i_full_en, i_full_src, i_full_dst, i_ptr_sel, i_prog_literal} = '0;
		{i_bank_select_value, i_extended_set_enable, i_accum} = '0;
		repeat (20) @(negedge i_clk);
		i_reset = 1'h0;
		@(negedge i_clk);
		chk("reset flags", o_flags, 8'h00);
		for (int i = 0; i < 4; i++) begin
			i_literal = ka[i];
			i_accum = kw[i];
			ex(`DAAF_OP_ADD_IMM, 8'h00, 1'h0, 1'h0);
			chk("add", {ad, o_flags[4:0]}, fl(ka[i], kw[i], 1'h0));
			ex(`DAAF_OP_SUB_IMM, 8'h00, 1'h0, 1'h0);
			chk("sub", {ad, o_flags[4:0]}, fl(ka[i], ~kw[i], 1'h1));
		end
		i_bank_select_value = 4'h1;
		i_accum = 8'h01;
		ex(`DAAF_OP_ADD_REG, 8'h40, 1'h1, 1'h1);
		chk("bank read", {rd, ra}, {1'h1, 12'h140});
		chk("file write", {wr, aw, wa, wd}, {2'h2, 12'h140, 8'h7d});
		ex(`DAAF_OP_ADD_REG, 8'h41, 1'h1, 1'h0);
		chk("acc write", {wr, aw, ad}, {2'h1, 8'h7e});
		ex(`DAAF_OP_SUB_REG, 8'h42, 1'h1, 1'h0);
		chk("sub reg", {ad, o_flags[4:0]}, fl(8'h7e, 8'hfe, 1'h1));
		ex(`DAAF_OP_AND_REG, 8'h42, 1'h1, 1'h0);
		chk("and zero", {ad, o_flags[4], o_flags[2]}, {8'h00, 2'h1});
		ex(`DAAF_OP_IOR_REG, 8'hc3, 1'h1, 1'h0);
		chk("ior neg", {ad, o_flags[4], o_flags[2]}, {8'hff, 2'h2});
		ex(`DAAF_OP_XOR_REG, 8'h3d, 1'h1, 1'h0);
		chk("xor zero", {ad, o_flags[4], o_flags[2]}, {8'h00, 2'h1});
		ex(`DAAF_OP_ROT_R, 8'h2c, 1'h1, 1'h0);
		chk("rot right", o_flags[1:0], 2'h2);
		ex(`DAAF_OP_ROT_L, 8'hb4, 1'h1, 1'h0);
		chk("rot left", o_flags[1:0], 2'h3);
		i_bank_select_value = 4'h2;
		i_bit_sel = 3'h5;
		fs = o_flags;
		foreach (nop[i]) begin
			ex(nop[i], 8'h10, 1'h1, 1'h1);
			chk("neutral flags", o_flags, fs);
			chk("neutral data", {wr, wd}, {1'h1, kd[i]});
		end
		{i_full_en, i_full_src, i_full_dst, i_bank_select_value} = {1'h1, 24'h123456, 4'h5};
		ex(`DAAF_OP_MOVE_FULL, 8'h00, 1'h1, 1'h1);
		chk("full move", {ra, wa, wd}, {12'h123, 12'h456, 8'h1f});
		i_full_en = 1'h0;
		ex(`DAAF_OP_ADD_REG, 8'h20, 1'h0, 1'h0);
		chk("access low", ra, 12'h020);
		ex(`DAAF_OP_ADD_REG, 8'h90, 1'h0, 1'h0);
		chk("access high", ra, 12'hf90);
		{i_ptr_sel, i_full_src} = {2'h2, 12'h300};
		ex(`DAAF_OP_LOAD_PTR, 8'h00, 1'h0, 1'h0);
		i_extended_set_enable = 1'h1;
		ex(`DAAF_OP_ADD_REG, 8'h20, 1'h0, 1'h0);
		chk("indexed literal", ra, 12'h320);
		i_extended_set_enable = 1'h0;
		{i_ptr_sel, i_full_src, i_accum} = {2'h0, 12'h0ff, 8'hfe};
		ex(`DAAF_OP_LOAD_PTR, 8'h00, 1'h0, 1'h0);
		foreach (pf[i]) begin
			ex(`DAAF_OP_MOVE_REG, pf[i], 1'h0, 1'h0);
			chk("ptr access", {rd, ra, ad}, {1'h1, pa[i], pa[i][7:0] ^ 8'h3c});
		end
		ex(`DAAF_OP_MOVE_REG, 8'he9, 1'h0, 1'h0);
		chk("ptr high", {rd, ad}, {1'h0, 8'h01});
		fs = o_flags;
		i_accum = 8'h55;
		ex(`DAAF_OP_STORE_ACC, 8'hee, 1'h0, 1'h0);
		chk("store ind", {wr, wa, wd, o_flags}, {1'h1, 12'h100, 8'h55, fs});
		ex(`DAAF_OP_MOVE_REG, 8'he8, 1'h0, 1'h0);
		chk("ptr low", ad, 8'h01);
		i_accum = 8'hff;
		ex(`DAAF_OP_STORE_ACC, 8'he9, 1'h0, 1'h0);
		ex(`DAAF_OP_MOVE_REG, 8'he9, 1'h0, 1'h0);
		chk("ptr high mask", ad, 8'h0f);
		{i_full_src, i_accum} = {12'hfe8, 8'h42};
		ex(`DAAF_OP_LOAD_PTR, 8'h00, 1'h0, 1'h0);
		ex(`DAAF_OP_STORE_ACC, 8'hee, 1'h0, 1'h0);
		chk("self write strobe", wr, 1'h0);
		ex(`DAAF_OP_MOVE_REG, 8'he8, 1'h0, 1'h0);
		chk("self write", ad, 8'h42);
		i_accum = 8'hff;
		{i_ptr_sel, i_full_src} = {2'h1, 12'hfef};
		ex(`DAAF_OP_LOAD_PTR, 8'h00, 1'h0, 1'h0);
		ex(`DAAF_OP_MOVE_REG, 8'he7, 1'h0, 1'h0);
		chk("operand read", {rd, ad}, 9'h000);
		ex(`DAAF_OP_STORE_ACC, 8'he7, 1'h0, 1'h0);
		chk("operand write", wr, 1'h0);
		ex(`DAAF_OP_STORE_ACC, 8'hd0, 1'h0, 1'h0);
		chk("flags store", o_flags, 8'h1f);
		i_accum = 8'h01;
		ex(`DAAF_OP_ADD_REG, 8'hd0, 1'h0, 1'h1);
		chk("flags dest", {wr, o_flags}, 9'h002);
		ex(`DAAF_OP_CLEAR, 8'hd0, 1'h0, 1'h1);
		chk("flags clear", o_flags, 8'h06);
		i_prog_literal = 20'habcde;
		ex(`DAAF_OP_PROG_JUMP, 8'h00, 1'h0, 1'h0);
		chk("jump", {pl, o_prog_target}, {1'h1, 20'habcde});
		results;
	end
endmodule
bind daaf_core daaf_core_properties #(.PROG_W(PROG_W)) u_prop (.i_clk, .i_reset, .i_instr_valid,
	.i_op, .i_file, .i_access, .i_dest, .i_literal, .i_prog_literal, .i_bank_select_value,
	.i_extended_set_enable, .i_accum, .o_busy, .o_done, .o_mem_addr, .o_mem_rd, .o_mem_wr,
	.o_accum_wr, .o_flags, .o_prog_load, .o_prog_target);
